// *** include/rgb_pkg.sv ***
// rgb_pkg: constants, command codes, states and carriers of the rgb dimming controller.
// assumes a single 20 MHz clock; the serial link is sampled, not clocked from.
//
// Summary of operation
// - a triggered ramp walks the current position to the up or down target.
// - per-step duration comes from the step time register; one to thirty-one 8 ms units, zero acting as one.
// - current position is clamped between zero and the maximum current position.
// - the peak current command applies its value directly at the byte acknowledge.
// - the transition starts when the triggering command byte is acknowledged.
// - each parameter register loads from its own single command byte.
// - command bits 7:5 select shutdown, peak, three duties, up, down or step time.
// - the step time command stores bits 4:0 and starts the ramp.
// - step count is the absolute difference between present and target position, zero if the target lies against the direction.
// - total ramp time is step time times step count, with no division.
// - step time field is binary with an 8 ms least significant weight.
// - target values are step positions mapped to current by the step table.
// - each duty generator uses a 5-bit value giving 32 levels.
// - a duty of zero holds that output fully off.
// - a duty of all ones holds that output continuously on.
// - intermediate duties step by 3.125 percent at about 2.1 kHz.
// - duty generators run independently, reload any time, never touch peak current.
// - no command sequence leads to an undefined or uncontrolled state.
// - receive-only slave at 7-bit address 0x38, every data byte of a transfer taken as a command.
// - position zero gives zero current; positions 30 and 31 give the same maximum.
// - peak current applies to all three outputs and never engages the ramp.
package rgb_pkg;

  // ==========================================================
  // clocking and timing
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned STEP_LSB_MS      = 8;
  localparam int unsigned STEP_UNIT_CYCLES = STEP_LSB_MS * (CLK_HZ / 1000);
  localparam int unsigned PWM_FREQ_HZ      = 2100;
  localparam int unsigned PWM_LEVELS       = 32;
  localparam int unsigned PWM_SLOT_CYCLES  = CLK_HZ / (PWM_FREQ_HZ * PWM_LEVELS);

  // ==========================================================
  // link address, fields and values
  localparam logic [6:0] SLAVE_ADDR = 7'h38;
  localparam logic [4:0] REG_RESET  = 5'h00;
  localparam logic [4:0] POS_MAX    = 5'h1F;
  localparam logic [4:0] POS_TOP    = 5'h1E;
  localparam logic [4:0] DUTY_FULL  = 5'h1F;
  localparam logic [3:0] BITS_BYTE  = 4'h8;

  // ==========================================================
  // command selector codes, bits 7:5
  localparam logic [2:0] SEL_SHUTDOWN = 3'h0;
  localparam logic [2:0] SEL_PEAK     = 3'h1;
  localparam logic [2:0] SEL_DUTY1    = 3'h2;
  localparam logic [2:0] SEL_DUTY2    = 3'h3;
  localparam logic [2:0] SEL_DUTY3    = 3'h4;
  localparam logic [2:0] SEL_UP       = 3'h5;
  localparam logic [2:0] SEL_DOWN     = 3'h6;
  localparam logic [2:0] SEL_STEP     = 3'h7;

  // ==========================================================
  // carriers and states
  typedef struct packed {
    logic [2:0] sel;
    logic [4:0] val;
  } rgb_cmd_t;

  typedef struct packed {
    logic [2:0] led_on;
    logic [4:0] level;
  } rgb_drive_t;

  typedef enum logic [2:0] {
    LNK_IDLE     = 3'b000,
    LNK_ADDR     = 3'b001,
    LNK_ACK_ADDR = 3'b010,
    LNK_DATA     = 3'b011,
    LNK_ACK_DATA = 3'b100,
    LNK_SKIP     = 3'b101
  } rgb_link_state_t;

  // distance between two step positions
  function automatic logic [4:0] rgb_dist(input logic [4:0] a, input logic [4:0] b);
    rgb_dist = (a > b) ? 5'(a - b) : 5'(b - a);
  endfunction : rgb_dist

  // pwm gate: zero is off, full is on, otherwise phase below duty
  function automatic logic rgb_gate(input logic [4:0] duty, input logic [4:0] phase);
    rgb_gate = (duty == DUTY_FULL) ? 1'b1 : (phase < duty);
  endfunction : rgb_gate

endpackage : rgb_pkg

// *** logic/rgb_dimming_ctrl.sv ***
// rgb_dimming_ctrl: serial command receiver, parameter registers, ramp engine and three pwm gates.
// assumes scl and sda arrive asynchronously from an open-drain bus; sda is driven only low.
`timescale 1ns/100ps
module rgb_dimming_ctrl #(
  parameter int unsigned STEP_CYCLES = rgb_pkg::STEP_UNIT_CYCLES
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // serial link pins
  input  wire logic              scl,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  // led drive
  output rgb_pkg::rgb_drive_t    led_drive,
  output logic                   ramp_active
);
  import rgb_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic scl_s1, scl_s2, scl_d;
  logic sda_s1, sda_s2, sda_d;

  // two flops per pin, then one history flop for edges
  always_ff @(posedge clk) begin
    scl_s1 <= scl;
    scl_s2 <= scl_s1;
    scl_d  <= scl_s2;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    sda_d  <= sda_s2;
  end

  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire bus_stop  = scl_s2 & scl_d & ~sda_d & sda_s2;

  // ==========================================================
  // byte receiver
  rgb_link_state_t state;
  logic [3:0]      bit_cnt;
  logic [7:0]      shift;

  wire byte_full = (bit_cnt == BITS_BYTE);
  wire shifting  = (state == LNK_ADDR) || (state == LNK_DATA);
  wire addr_hit  = (shift[7:1] == SLAVE_ADDR) && !shift[0];

  // link state machine; ack driven from falling scl to falling scl
  always_ff @(posedge clk) begin
    if (srst) begin
      state   <= LNK_IDLE;
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
      sda_oe  <= 1'b0;
    end else if (bus_start) begin
      state   <= LNK_ADDR;
      bit_cnt <= 4'h0;
      sda_oe  <= 1'b0;
    end else if (bus_stop) begin
      state   <= LNK_IDLE;
      sda_oe  <= 1'b0;
    end else if (scl_rise && shifting && !byte_full) begin
      shift   <= {shift[6:0], sda_s2};
      bit_cnt <= 4'(bit_cnt + 4'h1);
    end else if (scl_fall) begin
      unique case (state)
        LNK_ADDR: begin
          if (byte_full) begin
            state  <= addr_hit ? LNK_ACK_ADDR : LNK_SKIP;
            sda_oe <= addr_hit;
          end
        end
        LNK_DATA: begin
          if (byte_full) begin
            state  <= LNK_ACK_DATA;
            sda_oe <= 1'b1;
          end
        end
        LNK_ACK_ADDR, LNK_ACK_DATA: begin
          state   <= LNK_DATA;
          bit_cnt <= 4'h0;
          sda_oe  <= 1'b0;
        end
        LNK_IDLE, LNK_SKIP: begin
          state <= state;
        end
        default: begin
          state  <= LNK_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  assign sda_out = 1'b0;

  // ==========================================================
  // command decode at the acknowledge of a data byte
  wire      cmd_fire = scl_fall && !bus_start && !bus_stop && (state == LNK_DATA) && byte_full;
  rgb_cmd_t cmd;
  assign cmd = shift;

  wire wr_shut  = cmd_fire && (cmd.sel == SEL_SHUTDOWN);
  wire wr_peak  = cmd_fire && (cmd.sel == SEL_PEAK);
  wire wr_duty1 = cmd_fire && (cmd.sel == SEL_DUTY1);
  wire wr_duty2 = cmd_fire && (cmd.sel == SEL_DUTY2);
  wire wr_duty3 = cmd_fire && (cmd.sel == SEL_DUTY3);
  wire wr_up    = cmd_fire && (cmd.sel == SEL_UP);
  wire wr_down  = cmd_fire && (cmd.sel == SEL_DOWN);
  wire wr_step  = cmd_fire && (cmd.sel == SEL_STEP);

  // ==========================================================
  // parameter registers, one command byte each
  logic [4:0] duty_channel_one, duty_channel_two, duty_channel_three;
  logic [4:0] ramp_up_target, ramp_down_target, ramp_step_time;
  logic       dir_up;

  always_ff @(posedge clk) begin
    if (srst) begin
      duty_channel_one   <= REG_RESET;
      duty_channel_two   <= REG_RESET;
      duty_channel_three <= REG_RESET;
      ramp_up_target     <= REG_RESET;
      ramp_down_target   <= REG_RESET;
      ramp_step_time     <= REG_RESET;
      dir_up             <= 1'b0;
    end else begin
      if (wr_duty1) duty_channel_one   <= cmd.val;
      if (wr_duty2) duty_channel_two   <= cmd.val;
      if (wr_duty3) duty_channel_three <= cmd.val;
      if (wr_up)    ramp_up_target     <= cmd.val;
      if (wr_down)  ramp_down_target   <= cmd.val;
      if (wr_step)  ramp_step_time     <= cmd.val;
      if (wr_up || wr_down) dir_up     <= wr_up;
    end
  end

  // ==========================================================
  // ramp timebase: one unit is 8 ms, one step is field units
  logic [17:0] unit_cnt;
  logic [4:0]  unit_in_step;
  logic        ramp_busy;
  logic [4:0]  steps_left;
  logic [4:0]  peak_current_level;

  wire        unit_pulse = (unit_cnt == 18'(STEP_CYCLES - 1));
  wire [4:0]  step_units = (ramp_step_time == 5'h00) ? 5'h01 : ramp_step_time;
  wire        step_tick  = ramp_busy && unit_pulse && (unit_in_step == 5'(step_units - 5'h01));

  // unit counter restarts with each ramp so the first step is whole
  always_ff @(posedge clk) begin
    if (srst || wr_step || !ramp_busy) begin
      unit_cnt     <= 18'h0_0000;
      unit_in_step <= 5'h00;
    end else if (unit_pulse) begin
      unit_cnt     <= 18'h0_0000;
      unit_in_step <= step_tick ? 5'h00 : 5'(unit_in_step + 5'h01);
    end else begin
      unit_cnt     <= 18'(unit_cnt + 18'h0_0001);
    end
  end

  // ==========================================================
  // ramp engine and current position
  wire [4:0] ramp_end_value = dir_up ? ramp_up_target : ramp_down_target;
  wire       dir_ok         = dir_up ? (ramp_end_value >= peak_current_level)
                                     : (ramp_end_value <= peak_current_level);
  wire [4:0] start_steps    = dir_ok ? rgb_dist(peak_current_level, ramp_end_value) : 5'h00;
  wire [4:0] stepped_pos    = dir_up ? ((peak_current_level == POS_MAX) ? POS_MAX
                                                                        : 5'(peak_current_level + 5'h01))
                                     : ((peak_current_level == 5'h00) ? 5'h00
                                                                      : 5'(peak_current_level - 5'h01));

  // direct writes win over a running step; shutdown aborts the ramp
  always_ff @(posedge clk) begin
    if (srst) begin
      peak_current_level <= REG_RESET;
      ramp_busy          <= 1'b0;
      steps_left         <= 5'h00;
    end else if (wr_shut) begin
      peak_current_level <= 5'h00;
      ramp_busy          <= 1'b0;
      steps_left         <= 5'h00;
    end else if (wr_peak) begin
      peak_current_level <= cmd.val;
      ramp_busy          <= 1'b0;
      steps_left         <= 5'h00;
    end else if (wr_step) begin
      ramp_busy          <= (start_steps != 5'h00);
      steps_left         <= start_steps;
    end else if (step_tick) begin
      peak_current_level <= stepped_pos;
      steps_left         <= 5'(steps_left - 5'h01);
      ramp_busy          <= (steps_left != 5'h01);
    end
  end

  assign ramp_active = ramp_busy;

  // ==========================================================
  // pwm: 32 slots per period, slot rate near 32 x 2.1 kHz
  logic [8:0] slot_cnt;
  logic [4:0] phase;
  wire        slot_pulse = (slot_cnt == 9'(PWM_SLOT_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (srst) begin
      slot_cnt <= 9'h000;
      phase    <= 5'h00;
    end else if (slot_pulse) begin
      slot_cnt <= 9'h000;
      phase    <= 5'(phase + 5'h01);
    end else begin
      slot_cnt <= 9'(slot_cnt + 9'h001);
    end
  end

  // registered drive: gates per channel, level clamped so 31 acts as 30
  wire [2:0] next_led_on = {rgb_gate(duty_channel_three, phase),
                            rgb_gate(duty_channel_two, phase),
                            rgb_gate(duty_channel_one, phase)};
  wire [4:0] next_level  = (peak_current_level > POS_TOP) ? POS_TOP : peak_current_level;

  always_ff @(posedge clk) begin
    if (srst) begin
      led_drive <= '0;
    end else begin
      led_drive.led_on <= next_led_on;
      led_drive.level  <= next_level;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_ramp_start;
    wr_step && (start_steps != 5'h00);
  endsequence

  // acknowledge phase of a data byte: pin pulled low, link in its ack state
  sequence s_data_ack;
    sda_oe && (state == LNK_ACK_DATA);
  endsequence

  a_reset_clears: assert property ($fell(srst) |-> (peak_current_level == 5'h00) && !ramp_busy
                                   && (duty_channel_one == 5'h00) && (ramp_step_time == 5'h00))
    else $error("registers not zero after reset");

  a_peak_direct: assert property (wr_peak |=> (peak_current_level == $past(cmd.val)) && !ramp_busy)
    else $error("peak current not applied directly");

  a_shutdown_zero: assert property (wr_shut |=> (peak_current_level == 5'h00) ##1 (led_drive.level == 5'h00))
    else $error("shutdown did not zero the current");

  a_ramp_count: assert property (s_ramp_start |=> ramp_busy
                                 && (steps_left == rgb_dist($past(peak_current_level), $past(ramp_end_value))))
    else $error("ramp step count wrong");

  a_one_step: assert property (step_tick && !cmd_fire |=>
                               (rgb_dist(peak_current_level, $past(peak_current_level)) == 5'h01))
    else $error("ramp did not move one step");

  a_pos_hold: assert property (!step_tick && !cmd_fire |=> $stable(peak_current_level))
    else $error("position moved without a step");

  a_level_clamp: assert property (##1 (led_drive.level == (($past(peak_current_level) > POS_TOP) ? POS_TOP
                                                          : $past(peak_current_level))))
    else $error("drive level not clamped");

  a_duty_zero_off: assert property ((duty_channel_one == 5'h00) |=> !led_drive.led_on[0])
    else $error("zero duty output not off");

  a_duty_full_on: assert property ((duty_channel_two == DUTY_FULL) |=> led_drive.led_on[1])
    else $error("full duty output not on");

  a_ack_driven: assert property (cmd_fire |=> s_data_ack)
    else $error("data byte not acknowledged");

endmodule : rgb_dimming_ctrl

// *** dv/rgb_host_model.sv ***
// rgb_host_model: bus master that writes address and command bytes to the controller.
// assumes the bench resolves the open-drain data wire with a pull-up and feeds it back.
`timescale 1ns/100ps
module rgb_host_model (
  // clock
  input  wire logic clk,
  // bus wires
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  // ==========================================
  // bus timing
  int hp = 4; // clk cycles per half bus period, 400 ns period

  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // idle a number of clk edges
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  // one bit: data moves only while scl is low, sampled mid high
  task automatic put_bit(input logic b, output logic seen);
    scl <= 1'b0;
    wait_clk(hp / 2);
    sda_low <= ~b;
    wait_clk(hp - hp / 2);
    scl <= 1'b1;
    wait_clk(hp / 2);
    seen = sda_line;
    wait_clk(hp - hp / 2);
  endtask : put_bit

  // whole frame: start, address, one command byte, stop
  task automatic send(input logic [7:0] addr_byte, input logic [7:0] cmd_byte, output logic [1:0] acks);
    logic s;
    int   i;
    wait_clk(1);
    sda_low <= 1'b1; // start with scl high
    wait_clk(hp);
    for (i = 7; i >= 0; i--) put_bit(addr_byte[i], s);
    put_bit(1'b1, s);
    acks[1] = ~s;
    for (i = 7; i >= 0; i--) put_bit(cmd_byte[i], s); // one command byte per frame
    put_bit(1'b1, s);
    acks[0] = ~s;
    scl <= 1'b0;
    wait_clk(hp / 2);
    sda_low <= 1'b1;
    wait_clk(hp - hp / 2);
    scl <= 1'b1;
    wait_clk(hp);
    sda_low <= 1'b0; // stop
    wait_clk(hp);
  endtask : send
endmodule : rgb_host_model

// *** dv/rgb_led_dimming_controller_bench.sv ***
// rgb_led_dimming_controller_bench: self-checking bench for the dimming controller.
// assumes rgb_pkg compiled first; a pull-up holds the data wire high when released.
`timescale 1ns/100ps
module rgb_led_dimming_controller_bench;
  import rgb_pkg::*;
  // ==========================================
  // signals and model state
  localparam int unsigned SC  = 20;
  localparam int unsigned PER = PWM_LEVELS * PWM_SLOT_CYCLES;
  logic        clk       = 1'b0;
  logic        srst      = 1'b1;
  logic        scl;
  logic        sda_low;
  logic        sda_out;
  logic        sda_oe;
  logic        sda_line;
  rgb_drive_t  led_drive;
  logic        ramp_active;
  int          error_cnt = 0;
  int          checked   = 0;
  int          act_cnt   = 0;
  int          chg_cnt   = 0;
  int          on_cnt[3] = '{0, 0, 0};
  logic [4:0]  last_lvl  = 5'h00;
  logic [31:0] rnd_state = 32'h0000_E8F7;
  int          pos_m     = 0;
  int          dir_m     = 0;
  int          up_m      = 0;
  int          dn_m      = 0;

  // clock and resolved open-drain wire
  always #25 clk = ~clk;
  assign sda_line = ~(sda_low | (sda_oe & ~sda_out));

  rgb_dimming_ctrl #(.STEP_CYCLES(SC)) i_dut (.clk(clk), .srst(srst), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .led_drive(led_drive), .ramp_active(ramp_active));
  rgb_host_model i_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  // monitor on the falling edge, away from stimulus
  always @(negedge clk) begin
    act_cnt += ramp_active;
    if (led_drive.level !== last_lvl) chg_cnt++;
    last_lvl = led_drive.level;
    for (int k = 0; k < 3; k++) on_cnt[k] += led_drive.led_on[k];
  end

  // ==========================================
  // helpers
  function automatic logic [31:0] next_rand();
    rnd_state = rnd_state ^ (rnd_state << 13);
    rnd_state = rnd_state ^ (rnd_state >> 17);
    rnd_state = rnd_state ^ (rnd_state << 5);
    return rnd_state;
  endfunction : next_rand

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // one acknowledged command plus model update
  task automatic cmd(input logic [2:0] sel, input logic [4:0] v);
    rgb_cmd_t   c;
    logic [1:0] acks;
    c.sel = sel;
    c.val = v;
    i_host.send({SLAVE_ADDR, 1'b0}, c, acks);
    check(acks, 2'b11);
    case (sel)
      SEL_SHUTDOWN: pos_m = 0;
      SEL_PEAK: pos_m = v;
      SEL_UP: begin
        up_m  = v;
        dir_m = 1;
      end
      SEL_DOWN: begin
        dn_m  = v;
        dir_m = 0;
      end
      default: begin
      end
    endcase
  endtask : cmd

  // start a ramp and compare duration, step count and end level
  task automatic run_ramp(input logic [4:0] t);
    int a0;
    int c0;
    int st;
    int e;
    int n;
    a0 = act_cnt;
    c0 = chg_cnt;
    st = dir_m ? ((up_m > pos_m) ? up_m - pos_m : 0) : ((pos_m > dn_m) ? pos_m - dn_m : 0);
    e  = st * ((t == 0) ? 1 : t) * SC;
    cmd(SEL_STEP, t);
    n = 0;
    #1;
    while (ramp_active !== 1'b0 && n < 40000) begin
      tick(1);
      n++;
    end
    tick(3);
    if (st > 0) pos_m = dir_m ? up_m : dn_m;
    check(32'((act_cnt - a0 >= e - 1) && (act_cnt - a0 <= e + 1)), 32'd1);
    check(32'(chg_cnt - c0), 32'(st));
    check(led_drive.level, 32'((pos_m > 30) ? 30 : pos_m));
  endtask : run_ramp

  // ==========================================
  // main sequence
  initial begin
    int          it;
    int          k;
    int          o0[3];
    int          xp;
    logic [31:0] r;
    logic [4:0]  d[3];
    logic [1:0]  acks;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    tick(4);
    check(led_drive, 8'h00);
    check(ramp_active, 1'b0);
    // foreign address and read bit are ignored
    for (it = 0; it < 2; it++) begin
      i_host.send(it ? 8'h71 : 8'h72, {SEL_PEAK, 5'h07}, acks);
      tick(3);
      check(acks, 2'b00);
      check(led_drive.level, 5'h00);
    end
    // direct peak writes, including the clamped top
    for (it = 0; it < 2; it++) begin
      cmd(SEL_PEAK, it ? 5'h0A : 5'h1F);
      tick(3);
      check(led_drive.level, it ? 5'h0A : 5'h1E);
      check(ramp_active, 1'b0);
    end
    // each channel in turn off, full and a random duty
    for (it = 0; it < 3; it++) begin
      r = 1 + next_rand() % 30;
      for (k = 0; k < 3; k++) begin
        d[k] = (k == it) ? 5'h00 : ((k == (it + 1) % 3) ? DUTY_FULL : r[4:0]);
        cmd(3'(SEL_DUTY1 + k), d[k]);
      end
      for (k = 0; k < 3; k++) o0[k] = on_cnt[k];
      tick(PER);
      // full duty stays on for the whole period, not 31 of 32 slots
      for (k = 0; k < 3; k++) begin
        xp = (d[k] == DUTY_FULL) ? PER : d[k] * PWM_SLOT_CYCLES;
        check(32'(on_cnt[k] - o0[k]), 32'(xp));
      end
      check(led_drive.level, 5'h0A);
    end
    // documented example: five up to fifteen
    cmd(SEL_PEAK, 5'h05);
    cmd(SEL_UP, 5'h0F);
    run_ramp(5'h02);
    // random ramps both ways, prompt and slow host
    for (it = 0; it < 6; it++) begin
      i_host.hp = (it % 2) ? 7 : 4;
      r = next_rand();
      cmd(SEL_PEAK, 5'(r % 30));
      cmd(r[5] ? SEL_UP : SEL_DOWN, 5'((r >> 8) % 30));
      run_ramp(5'((r >> 16) % 4));
    end
    // shutdown aborts a running ramp
    i_host.hp = 4;
    cmd(SEL_PEAK, 5'h03);
    cmd(SEL_UP, 5'h1C);
    cmd(SEL_STEP, 5'h1F);
    tick(1);
    check(ramp_active, 1'b1);
    cmd(SEL_SHUTDOWN, 5'h15);
    tick(3);
    check(led_drive.level, 5'h00);
    check(ramp_active, 1'b0);
    finish_test();
  end

  // watchdog
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
endmodule : rgb_led_dimming_controller_bench
